// [core/sfid_pkg.sv]
// constants, opcodes, states and command codes for the serial flash instruction decoder
// assumes one core clock; the serial link is sampled as ordinary synchronous inputs
package sfid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OPC_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_AUTO_INCREMENT_PROGRAM = 8'had;
  localparam logic [7:0] OPC_STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] OPC_STATUS_WRITE_ENABLE_CMD = 8'h50;
  localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OPC_ID_READ_CMD_A = 8'h90;
  localparam logic [7:0] OPC_ID_READ_CMD_B = 8'hab;
  localparam logic [7:0] OPC_BUSY_OUTPUT_ON_CMD = 8'h70;
  localparam logic [7:0] OPC_BUSY_OUTPUT_OFF_CMD = 8'h80;
  localparam logic [7:0] OPC_HOLD_FUNCTION_ENABLE_CMD = 8'haa;

  ////////////////////////////////////////////////////////////////////////////
  // framing
  localparam int BITS_PER_CYCLE = 8;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [1:0] DATA_ONE_BYTE = 2'h1;
  localparam logic [1:0] DATA_TWO_BYTES = 2'h2;
  localparam int READ_MAX_SCK_HZ = 33_000_000;
  localparam int CORE_CLK_HZ = 50_000_000;
  localparam int SECTOR_LSB = 12;
  localparam int BLOCK32_LSB = 15;
  localparam int BLOCK64_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // status byte layout and reset values
  localparam int ST_BUSY_POS = 0;
  localparam int ST_WEL_POS = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_AAI_POS = 6;
  localparam int ST_BPL_POS = 7;
  localparam logic [3:0] BP_RESET = 4'h7;
  localparam logic BPL_RESET = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // commands handed to the array engine
  localparam int CMD_OP_W = 3;
  localparam logic [2:0] CMD_BYTE_PROGRAM = 3'h0;
  localparam logic [2:0] CMD_AUTO_INCREMENT_WORD = 3'h1;
  localparam logic [2:0] CMD_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] CMD_BLOCK32_ERASE = 3'h3;
  localparam logic [2:0] CMD_BLOCK64_ERASE = 3'h4;
  localparam logic [2:0] CMD_CHIP_ERASE = 3'h5;
  localparam int CMD_DATA_W = 16;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_OPCODE = 9'h002,
    ST_ADDR = 9'h004,
    ST_DUMMY = 9'h008,
    ST_DATA_IN = 9'h010,
    ST_NO_DATA = 9'h020,
    ST_DATA_OUT = 9'h040,
    ST_IGNORE = 9'h080,
    ST_PUSH = 9'h100
  } sfid_state_type;

endpackage

// [core/sfid_top.sv]
// serial flash instruction decoder: spi mode 0/3 framing, decode, read streaming
// assumes sck/cs/si synchronous to core_clk_i and sck well below half the core rate;
// the array answers mem_rd_data_i combinationally from mem_rd_addr_o
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// command fifo with registered head
module sfid_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i, // core clock
  input wire logic resetn_i, // async reset, active low
  input wire logic in_valid_i, // word offered
  input wire logic [WIDTH-1:0] in_data_i, // word to store
  output logic in_ready_o, // room for a word
  output logic out_valid_o, // head word present
  output logic [WIDTH-1:0] out_data_o, // head word
  input wire logic out_ready_i // head word taken
);
  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } sfid_fifo_type;

  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW:0] CNT_ONE = 1;
  localparam logic [PW-1:0] PTR_ONE = 1;

  sfid_fifo_type s_reg;
  sfid_fifo_type s_next;
  logic push;
  logic pop;

  assign in_ready_o = (s_reg.cnt != FULL_CNT);
  assign out_valid_o = s_reg.out_valid;
  assign out_data_o = s_reg.out_data;

  always_comb begin
    s_next = s_reg;
    push = in_valid_i && (s_reg.cnt != FULL_CNT);
    pop = s_reg.out_valid && out_ready_i;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data_i;
      s_next.wr = s_reg.wr + PTR_ONE;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + PTR_ONE;
    end
    if (push && !pop) begin
      s_next.cnt = s_reg.cnt + CNT_ONE;
    end else if (pop && !push) begin
      s_next.cnt = s_reg.cnt - CNT_ONE;
    end
    // head is kept in flops so the consumer sees registered outputs
    s_next.out_valid = (s_next.cnt != '0);
    s_next.out_data = s_next.mem[s_next.rd];
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // sfid_fifo

////////////////////////////////////////////////////////////////////////////////
// decoder top
module sfid_top
  import sfid_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'ha5 // arbitrary value
) (
  input wire logic core_clk_i, // core clock, 50 MHz
  input wire logic resetn_i, // async reset, active low
  input wire logic cs_n_i, // chip select, active low
  input wire logic sck_i, // serial clock from host
  input wire logic si_i, // serial data in
  output logic so_o, // serial data out
  output logic so_oe_o, // serial out driven
  input wire logic wp_n_i, // write protect, active low
  input wire logic busy_i, // array engine busy
  output logic [ADDR_W-1:0] mem_rd_addr_o, // array read address
  input wire logic [7:0] mem_rd_data_i, // array read data
  output logic hold_en_o, // hold function selected on shared pin
  output logic cmd_valid_o, // command word waiting
  output logic [CMD_OP_W-1:0] cmd_op_o, // command code
  output logic [ADDR_W-1:0] cmd_addr_o, // command address
  output logic [CMD_DATA_W-1:0] cmd_data_o, // program data: word program first byte high, byte program in the low byte
  input wire logic cmd_ready_i // command word taken
);
  localparam int CMD_W = CMD_OP_W + ADDR_W + CMD_DATA_W;

  generate
    if (ADDR_W < BLOCK64_LSB + 1 || ADDR_W > 24) begin : g_bad_addr
      $error("address width must lie between 17 and 24");
    end
  endgenerate

  typedef struct packed {
    sfid_state_type st;
    logic sck_q;
    logic cs_n_q;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] opc;
    logic [1:0] byte_cnt;
    logic [ADDR_W-1:0] addr;
    logic [15:0] din;
    logic [1:0] din_cnt;
    logic [7:0] tx;
    logic write_enable_latch;
    logic status_write_enable_cmd;
    logic auto_increment_program;
    logic [ADDR_W-1:0] aai_addr;
    logic protection_lock_bit;
    logic [3:0] bp;
    logic busy_out_en;
    logic hold_en;
    logic so;
    logic so_oe;
    logic [CMD_W-1:0] cmd;
  } sfid_regs_type;

  localparam logic [ADDR_W-1:0] A_ONE = 1;
  localparam logic [ADDR_W-1:0] A_TWO = 2;

  sfid_regs_type s_reg;
  sfid_regs_type s_next;
  logic fifo_ready;
  logic [CMD_W-1:0] fifo_out;

  function automatic logic [ADDR_W-1:0] low_clear(input logic [ADDR_W-1:0] a, input int lsb);
    logic [ADDR_W-1:0] m;
    m = '1;
    m = m << lsb;
    return a & m;
  endfunction

  function automatic logic is_id_read(input logic [7:0] op);
    return (op == OPC_ID_READ_CMD_A) || (op == OPC_ID_READ_CMD_B);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] b;
    logic [7:0] src;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic busy;
    logic [ADDR_W-1:0] base;
    b = {s_reg.sh[6:0], si_i};
    src = '0;
    base = '0;
    s_next = s_reg;
    s_next.sck_q = sck_i;
    s_next.cs_n_q = cs_n_i;
    sck_rise = sck_i && !s_reg.sck_q && !cs_n_i;
    sck_fall = !sck_i && s_reg.sck_q && !cs_n_i;
    cs_fall = !cs_n_i && s_reg.cs_n_q;
    cs_rise = cs_n_i && !s_reg.cs_n_q;
    // queued or in-flight work counts as busy to the host
    busy = busy_i || (s_reg.st == ST_PUSH) || cmd_valid_o;

    if (cs_rise) begin
      s_next.st = (s_reg.st == ST_PUSH) ? ST_PUSH : ST_IDLE;
      s_next.so_oe = 1'b0;
      if (s_reg.bit_cnt == 3'h0 &&
          (s_reg.st == ST_NO_DATA || s_reg.st == ST_DATA_IN)) begin
        if (s_reg.opc != OPC_STATUS_WRITE_ENABLE_CMD) begin
          s_next.status_write_enable_cmd = 1'b0;
        end
        unique case (s_reg.opc)
          OPC_WRITE_ENABLE_CMD: s_next.write_enable_latch = 1'b1;
          OPC_WRITE_DISABLE_CMD: begin
            s_next.write_enable_latch = 1'b0;
            s_next.auto_increment_program = 1'b0;
          end
          OPC_STATUS_WRITE_ENABLE_CMD: s_next.status_write_enable_cmd = 1'b1;
          OPC_BUSY_OUTPUT_ON_CMD: s_next.busy_out_en = 1'b1;
          OPC_BUSY_OUTPUT_OFF_CMD: s_next.busy_out_en = 1'b0;
          OPC_HOLD_FUNCTION_ENABLE_CMD: s_next.hold_en = 1'b1;
          OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
            s_next.cmd = {CMD_CHIP_ERASE, {ADDR_W{1'b0}}, 16'h0000};
            s_next.st = ST_PUSH;
            s_next.write_enable_latch = 1'b0;
          end
          OPC_SECTOR_ERASE: begin
            s_next.cmd = {CMD_SECTOR_ERASE, low_clear(s_reg.addr, SECTOR_LSB), 16'h0000};
            s_next.st = ST_PUSH;
            s_next.write_enable_latch = 1'b0;
          end
          OPC_BLOCK32_ERASE: begin
            s_next.cmd = {CMD_BLOCK32_ERASE, low_clear(s_reg.addr, BLOCK32_LSB), 16'h0000};
            s_next.st = ST_PUSH;
            s_next.write_enable_latch = 1'b0;
          end
          OPC_BLOCK64_ERASE: begin
            s_next.cmd = {CMD_BLOCK64_ERASE, low_clear(s_reg.addr, BLOCK64_LSB), 16'h0000};
            s_next.st = ST_PUSH;
            s_next.write_enable_latch = 1'b0;
          end
          OPC_BYTE_PROGRAM: begin
            if (s_reg.din_cnt == DATA_ONE_BYTE) begin
              s_next.cmd = {CMD_BYTE_PROGRAM, s_reg.addr, 8'h00, s_reg.din[7:0]};
              s_next.st = ST_PUSH;
              s_next.write_enable_latch = 1'b0;
            end
          end
          OPC_AUTO_INCREMENT_PROGRAM: begin
            if (s_reg.din_cnt == DATA_TWO_BYTES) begin
              // first entry takes the sent address with bit 0 forced even
              base = s_reg.auto_increment_program ? s_reg.aai_addr : (s_reg.addr & ~A_ONE);
              s_next.cmd = {CMD_AUTO_INCREMENT_WORD, base, s_reg.din};
              s_next.st = ST_PUSH;
              s_next.auto_increment_program = 1'b1;
              s_next.aai_addr = base + A_TWO;
              // no wrap while word programming: leaving the top ends the sequence
              if (base + A_TWO == '0) begin
                s_next.auto_increment_program = 1'b0;
                s_next.write_enable_latch = 1'b0;
              end
            end
          end
          OPC_STATUS_WRITE_CMD: begin
            if (s_reg.din_cnt == DATA_ONE_BYTE) begin
              if (wp_n_i || !s_reg.protection_lock_bit) begin
                s_next.bp = s_reg.din[ST_BP_LSB+3:ST_BP_LSB];
                s_next.protection_lock_bit = s_reg.din[ST_BPL_POS];
              end
              s_next.write_enable_latch = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end else if (cs_fall) begin
      if (s_reg.st == ST_IDLE) begin
        s_next.st = ST_OPCODE;
        s_next.bit_cnt = 3'h0;
        s_next.byte_cnt = 2'h0;
        s_next.din_cnt = 2'h0;
      end
    end else if (sck_rise) begin
      s_next.sh = b;
      s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
      if (s_reg.bit_cnt == 3'(BITS_PER_CYCLE - 1)) begin
        unique case (s_reg.st)
          ST_OPCODE: begin
            s_next.opc = b;
            s_next.st = ST_IGNORE;
            if (s_reg.auto_increment_program && b != OPC_AUTO_INCREMENT_PROGRAM && b != OPC_STATUS_READ_CMD &&
                b != OPC_WRITE_DISABLE_CMD) begin
              s_next.st = ST_IGNORE;
            end else begin
              unique case (b)
                OPC_READ, OPC_FAST_READ, OPC_ID_READ_CMD_A, OPC_ID_READ_CMD_B:
                  s_next.st = ST_ADDR;
                OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE, OPC_BYTE_PROGRAM:
                  s_next.st = s_reg.write_enable_latch ? ST_ADDR : ST_IGNORE;
                OPC_AUTO_INCREMENT_PROGRAM:
                  s_next.st = s_reg.auto_increment_program ? ST_DATA_IN : (s_reg.write_enable_latch ? ST_ADDR : ST_IGNORE);
                OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B:
                  s_next.st = s_reg.write_enable_latch ? ST_NO_DATA : ST_IGNORE;
                OPC_STATUS_WRITE_CMD:
                  s_next.st = (s_reg.write_enable_latch || s_reg.status_write_enable_cmd) ? ST_DATA_IN : ST_IGNORE;
                OPC_STATUS_READ_CMD:
                  s_next.st = ST_DATA_OUT;
                OPC_WRITE_ENABLE_CMD, OPC_WRITE_DISABLE_CMD, OPC_STATUS_WRITE_ENABLE_CMD,
                OPC_BUSY_OUTPUT_ON_CMD, OPC_BUSY_OUTPUT_OFF_CMD,
                OPC_HOLD_FUNCTION_ENABLE_CMD:
                  s_next.st = ST_NO_DATA;
                default: s_next.st = ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            s_next.addr = {s_reg.addr[ADDR_W-9:0], b};
            s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
            if (s_reg.byte_cnt == ADDR_LAST_BYTE) begin
              unique case (s_reg.opc)
                OPC_FAST_READ: s_next.st = ST_DUMMY;
                OPC_READ, OPC_ID_READ_CMD_A, OPC_ID_READ_CMD_B:
                  s_next.st = ST_DATA_OUT;
                OPC_BYTE_PROGRAM, OPC_AUTO_INCREMENT_PROGRAM: s_next.st = ST_DATA_IN;
                default: s_next.st = ST_NO_DATA;
              endcase
            end
          end
          ST_DUMMY: s_next.st = ST_DATA_OUT;
          ST_DATA_IN: begin
            s_next.din = {s_reg.din[7:0], b};
            if (s_reg.din_cnt != 2'h3) begin
              s_next.din_cnt = s_reg.din_cnt + 2'h1;
            end
          end
          default: ;
        endcase
      end
    end else if (sck_fall && s_reg.st == ST_DATA_OUT) begin
      if (s_reg.bit_cnt == 3'h0) begin
        if (s_reg.opc == OPC_STATUS_READ_CMD) begin
          src = {s_reg.protection_lock_bit, s_reg.auto_increment_program, s_reg.bp, s_reg.write_enable_latch, busy};
        end else if (is_id_read(s_reg.opc)) begin
          src = s_reg.addr[0] ? PART_CODE : MAKER_CODE;
        end else begin
          src = mem_rd_data_i;
          s_next.addr = s_reg.addr + A_ONE;
        end
        s_next.tx = src;
        s_next.so = src[7];
      end else begin
        s_next.so = s_reg.tx[~s_reg.bit_cnt];
      end
      s_next.so_oe = 1'b1;
    end

    if (s_reg.st == ST_PUSH && fifo_ready) begin
      // a select that fell while the word waited is not framed
      s_next.st = cs_n_i ? ST_IDLE : ST_IGNORE;
    end

    // ready/busy drives serial out while word programming is selected, except while data shifts out
    if (!cs_n_i && !cs_fall && s_reg.auto_increment_program && s_reg.busy_out_en &&
        s_next.st != ST_DATA_OUT) begin
      s_next.so = !busy;
      s_next.so_oe = 1'b1;
    end else if (cs_n_i || s_next.st != ST_DATA_OUT) begin
      s_next.so_oe = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.sck_q <= 1'b0;
      s_reg.cs_n_q <= 1'b1;
      s_reg.bp <= BP_RESET;
      s_reg.protection_lock_bit <= BPL_RESET;
      s_reg.write_enable_latch <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a full queue holds the decoder in the push state and shows as busy
  sfid_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(s_reg.st == ST_PUSH),
    .in_data_i(s_reg.cmd),
    .in_ready_o(fifo_ready),
    .out_valid_o(cmd_valid_o),
    .out_data_o(fifo_out),
    .out_ready_i(cmd_ready_i)
  );

  assign cmd_op_o = fifo_out[CMD_W-1 -: CMD_OP_W];
  assign cmd_addr_o = fifo_out[CMD_DATA_W +: ADDR_W];
  assign cmd_data_o = fifo_out[CMD_DATA_W-1:0];
  assign so_o = s_reg.so;
  assign so_oe_o = s_reg.so_oe;
  assign mem_rd_addr_o = s_reg.addr;
  assign hold_en_o = s_reg.hold_en;
endmodule // sfid_top

// [verif/sfid_host_model.sv]
// host spi controller model, mode 0, bit-banged off the core clock
// assumes clk_i is the device core clock; sck runs at one eighth of it
`timescale 1ns/1ps
module sfid_host_model (
  input wire logic clk_i, // core clock
  output logic cs_n_o, // chip select, active low
  output logic sck_o, // serial clock, idle low
  output logic si_o, // serial data to device
  input wire logic so_i // serial data from device
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // four samples per sck level, the device needs at least two
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic select();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    half();
  endtask
  // nbits below eight cuts the byte short on purpose
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_o = tx[i];
      half();
      sck_o = 1'b1;
      rx[i] = so_i;
      half();
      sck_o = 1'b0;
    end
  endtask
  task automatic deselect();
    half();
    cs_n_o = 1'b1;
    si_o = ~si_o; // released line, no stale level
    repeat (8) @(negedge clk_i);
  endtask
endmodule // sfid_host_model

// [verif/sfid_top_asserts.sv]
// checker for the decoder top: command words and output enable
// assumes it is bound onto sfid_top and sees only its ports
`timescale 1ns/1ps
module sfid_top_asserts
  import sfid_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic core_clk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic cs_n_i, // chip select
  input wire logic so_oe_o, // output enable
  input wire logic hold_en_o, // hold selected
  input wire logic cmd_valid_o, // word waiting
  input wire logic [CMD_OP_W-1:0] cmd_op_o, // code
  input wire logic [ADDR_W-1:0] cmd_addr_o, // address
  input wire logic [CMD_DATA_W-1:0] cmd_data_o, // data
  input wire logic cmd_ready_i // word taken
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_oe_idle: assert property (
    cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) |-> !so_oe_o)
    else $error("serial output driven while deselected");
  chk_cmd_stable: assert property (
    cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_addr_o)
    && $stable(cmd_data_o) && $stable(cmd_op_o))
    else $error("command word changed before taken");
  chk_sector_align: assert property (
    cmd_valid_o && cmd_op_o == CMD_SECTOR_ERASE |-> cmd_addr_o[SECTOR_LSB-1:0] == '0)
    else $error("sector address not aligned");
  chk_blk32_align: assert property (
    cmd_valid_o && cmd_op_o == CMD_BLOCK32_ERASE |-> cmd_addr_o[BLOCK32_LSB-1:0] == '0)
    else $error("32k block address not aligned");
  chk_blk64_align: assert property (
    cmd_valid_o && cmd_op_o == CMD_BLOCK64_ERASE |-> cmd_addr_o[BLOCK64_LSB-1:0] == '0)
    else $error("64k block address not aligned");
  chk_word_even: assert property (
    cmd_valid_o && cmd_op_o == CMD_AUTO_INCREMENT_WORD |-> !cmd_addr_o[0])
    else $error("word program address odd");
  chk_op_known: assert property (
    cmd_valid_o |-> cmd_op_o <= CMD_CHIP_ERASE)
    else $error("command code out of range");
  chk_hold_kept: assert property (
    hold_en_o |=> hold_en_o)
    else $error("hold function dropped");
endmodule // sfid_top_asserts
bind sfid_top sfid_top_asserts #(.ADDR_W(ADDR_W)) sfid_top_asserts_i (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o),
  .hold_en_o(hold_en_o), .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o),
  .cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o), .cmd_ready_i(cmd_ready_i));

// [verif/tb_top.sv]
// self-checking bench for the decoder: host model, array stub, command sink
// assumes a 50 MHz core clock and the default 20 bit address width
`timescale 1ns/1ps
module tb_top;
  import sfid_pkg::*;
  typedef struct {logic [2:0] op; logic [19:0] a; logic [19:0] am; logic [15:0] d;
    logic [15:0] dm;} sfid_exp_type;
  logic core_clk_i = 1'b0, resetn_i = 1'b0, cs_n_i, sck_i, si_i, so_o, so_oe_o;
  logic wp_n_i = 1'b1, busy_i = 1'b0, hold_en_o, cmd_valid_o, cmd_ready_i = 1'b1;
  logic [19:0] mem_rd_addr_o, cmd_addr_o, a;
  logic [7:0] mem_rd_data_i, rx[8], d;
  logic [2:0] cmd_op_o;
  logic [15:0] cmd_data_o;
  logic [31:0] rnd = 32'h80fd;
  int fail_count = 0, n_compared = 0;
  sfid_exp_type eq[$];
  always #10 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem_fn(logic [19:0] x);
    return x[7:0] ^ x[19:12] ^ 8'h3c;
  endfunction
  assign mem_rd_data_i = mem_fn(mem_rd_addr_o);
  sfid_top sfid_top_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .wp_n_i(wp_n_i),
    .busy_i(busy_i), .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_data_i(mem_rd_data_i),
    .hold_en_o(hold_en_o), .cmd_valid_o(cmd_valid_o), .cmd_op_o(cmd_op_o),
    .cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o), .cmd_ready_i(cmd_ready_i));
  sfid_host_model sfid_host_model_i (.clk_i(core_clk_i), .cs_n_o(cs_n_i), .sck_o(sck_i),
    .si_o(si_i), .so_i(so_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic flag(string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) flag($sformatf("byte %h, expected %h", got, exp));
  endtask
  task automatic chk_cmd();
    sfid_exp_type e;
    n_compared++;
    if (eq.size() == 0) begin
      flag("unexpected command word");
      return;
    end
    e = eq.pop_front();
    if (cmd_op_o !== e.op || (cmd_addr_o & e.am) !== (e.a & e.am)
        || (cmd_data_o & e.dm) !== e.d) flag($sformatf("command %h %h %h", cmd_op_o,
        cmd_addr_o, cmd_data_o));
  endtask
  always @(posedge core_clk_i) begin
    if (resetn_i && cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) chk_cmd();
  end
  task automatic push(logic [2:0] op, logic [19:0] x, logic [19:0] am, logic [15:0] dd,
      logic [15:0] dm);
    eq.push_back('{op, x & am, am, dd & dm, dm});
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // w holds nb bytes, lowest nb bytes, first sent from the top
  task automatic send(logic [63:0] w, int nb, int nrd);
    logic [7:0] dd;
    rnd = lfsr(rnd);
    sfid_host_model_i.select();
    for (int i = nb - 1; i >= 0; i--) sfid_host_model_i.xfer(w[8*i +: 8], 8, dd);
    for (int i = 0; i < nrd; i++) sfid_host_model_i.xfer(8'h00, 8, rx[i]);
    sfid_host_model_i.deselect();
  endtask
  task automatic st(logic [7:0] exp);
    send(64'h05, 1, 2);
    chk_byte(rx[0], exp);
    chk_byte(rx[1], exp);
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk_i);
    flag("timeout");
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [7:0] ops[5] = '{OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE,
      OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B};
    static logic [19:0] ams[5] = '{20'hff000, 20'hf8000, 20'hf0000, 20'h0, 20'h0};
    repeat (12) @(negedge core_clk_i);
    resetn_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    st(8'h1c);
    send(64'h06, 1, 0);
    st(8'h1e);
    send(64'h04, 1, 0);
    st(8'h1c);
    send({8'h02, rnd[23:0], 8'h55}, 5, 0);
    send({8'h20, rnd[23:0]}, 4, 0);
    $display("test write enable done");
    for (int k = 0; k < 5; k++) begin
      send(64'h06, 1, 0);
      push(k < 3 ? 3'(k + 2) : CMD_CHIP_ERASE, rnd[19:0], ams[k], 16'h0, 16'h0);
      send(k < 3 ? {32'h0, ops[k], rnd[23:0]} : {56'h0, ops[k]}, k < 3 ? 4 : 1, 0);
    end
    send(64'h06, 1, 0);
    push(CMD_BYTE_PROGRAM, rnd[19:0], 20'hfffff, {8'h0, rnd[31:24]}, 16'h00ff);
    send({8'h02, rnd[23:0], rnd[31:24]}, 5, 0);
    st(8'h1c);
    send(64'h06, 1, 0);
    sfid_host_model_i.select();
    for (int i = 0; i < 4; i++) sfid_host_model_i.xfer(i == 0 ? 8'h02 : 8'h11, 8, d);
    sfid_host_model_i.xfer(8'ha5, 4, d);
    sfid_host_model_i.deselect();
    st(8'h1e);
    send(64'h04, 1, 0);
    $display("test erase and program done");
    send(64'h03fffffe, 4, 4);
    for (int i = 0; i < 4; i++) chk_byte(rx[i], mem_fn(20'hffffe + 20'(i)));
    a = rnd[19:0];
    send({8'h0b, 4'h0, a, 8'h00}, 5, 3);
    for (int i = 0; i < 3; i++) chk_byte(rx[i], mem_fn(a + 20'(i)));
    send(64'h90000000, 4, 2);
    chk_byte(rx[1], 8'h5a);
    send(64'hab000001, 4, 2);
    chk_byte(rx[1], 8'ha5);
    $display("test reads done");
    send(64'h06, 1, 0);
    send(64'h0180, 2, 0);
    st(8'h80);
    wp_n_i = 1'b0;
    send(64'h06, 1, 0);
    send(64'h0100, 2, 0);
    st(8'h80);
    wp_n_i = 1'b1;
    send(64'h50, 1, 0);
    send(64'h0100, 2, 0);
    st(8'h00);
    send(64'h06, 1, 0);
    send(64'h9f, 1, 3);
    st(8'h02);
    send(64'h70, 1, 0);
    a = {1'b0, rnd[18:0]};
    push(CMD_AUTO_INCREMENT_WORD, a & 20'hffffe, 20'hfffff, rnd[31:16], 16'hffff);
    send({8'had, 4'h0, a, rnd[31:16]}, 6, 0);
    st(8'h42);
    push(CMD_AUTO_INCREMENT_WORD, (a & 20'hffffe) + 20'h2, 20'hfffff, rnd[15:0], 16'hffff);
    send({8'had, rnd[15:0]}, 3, 0);
    // ready/busy on the output pin while a word program sequence is open
    busy_i = 1'b1;
    sfid_host_model_i.select();
    chk_byte({6'h0, so_oe_o, so_o}, 8'h02);
    sfid_host_model_i.deselect();
    busy_i = 1'b0;
    send({8'h02, 4'h0, a, 8'h00}, 5, 0);
    send(64'h04, 1, 0);
    st(8'h00);
    send(64'h70, 1, 0);
    send(64'h80, 1, 0);
    send(64'haa, 1, 0);
    chk_byte({7'h0, hold_en_o}, 8'h01);
    busy_i = 1'b1;
    st(8'h01);
    busy_i = 1'b0;
    $display("test modes done");
    cmd_ready_i = 1'b0;
    for (int k = 0; k < 17; k++) begin
      send(64'h06, 1, 0);
      push(CMD_CHIP_ERASE, 20'h0, 20'h0, 16'h0, 16'h0);
      send(k[0] ? 64'hc7 : 64'h60, 1, 0);
    end
    // a select while the last word waits for room is refused, the word kept
    send(64'h06, 1, 0);
    for (int i = 0; i < 3000 && eq.size() > 0; i++) begin
      @(negedge core_clk_i);
      rnd = lfsr(rnd);
      cmd_ready_i = rnd[0];
    end
    cmd_ready_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk_byte(8'(eq.size()), 8'h00);
    st(8'h00);
    $display("test fifo fill and drain done");
    stop_test();
  end
endmodule // tb_top
